// [hdl/seesf_frontend.sv]
// SPI front end with suspend, write guard and opcode decode
`default_nettype none
module seesf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } seesf_fifo_s;
  seesf_fifo_s            st_reg;
  seesf_fifo_s            st_next;
  logic [WIDTH-1:0]       mem [DEPTH];
  logic                   push;
  logic                   pop;
  assign out_valid = st_reg.wp != st_reg.rp;
  assign in_ready  = !((st_reg.wp[AW] != st_reg.rp[AW])
                       && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]));
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_reg.rp[AW-1:0]];
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem[st_reg.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : seesf_fifo

////////////////////////////////////////////////////////////////////////////////

module seesf_frontend
  import seesf_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYC,
  parameter int FIFO_DEPTH   = 16
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       chip_sel_n,
  input  wire logic       ser_clk,
  input  wire logic       ser_in,
  input  wire logic       suspend_n,
  input  wire logic       write_guard_n,
  output logic            ser_out,
  output logic            ser_out_oe,
  input  wire logic [2:0] nv_bits_in,
  output logic      [2:0] nv_bits_out,
  output logic            nv_write_pulse,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  output logic            array_read_active,
  output logic            array_write_active,
  output logic      [7:0] status_value,
  output logic            selected
);
  import seesf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       guard_s1_reg;
  logic       guard_s2_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg    <= 4'hF;
      sync2_reg    <= 4'hF;
      guard_s1_reg <= 1'b1;
      guard_s2_reg <= 1'b1;
    end else begin
      sync1_reg    <= {chip_sel_n, ser_clk, ser_in, suspend_n};
      sync2_reg    <= sync1_reg;
      guard_s1_reg <= write_guard_n;
      guard_s2_reg <= guard_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    seesf_state_e state;
    logic [3:0]   prev;
    logic         guard_prev;
    logic         susp;
    logic [2:0]   bitcnt;
    logic [7:0]   shreg;
    logic [7:0]   txreg;
    logic         out_bit;
    logic         oe;
    logic         permit;
    logic [2:0]   nv;
    logic [2:0]   nv_pend;
    logic         wr_pend;
    logic         rd_array;
    logic         wr_array;
    logic         busy;
    logic [31:0]  wcnt;
    logic         nv_pulse;
    logic [7:0]   rxd;
    logic         rxv;
    logic         nv_loaded;
    logic         sr_wr;
  } seesf_s;
  seesf_s st_reg;
  seesf_s st_next;

  logic cs_n;
  logic sck;
  logic sdi;
  logic hold_n;
  logic fall_cs;
  logic rise_cs;
  logic rise_sck;
  logic fall_sck;
  logic guard_fall;
  logic [7:0] status_w;
  logic       fifo_in_ready;
  logic [7:0] fifo_out;
  logic       fifo_out_valid;

  assign cs_n   = sync2_reg[3];
  assign sck    = sync2_reg[2];
  assign sdi    = sync2_reg[1];
  assign hold_n = sync2_reg[0];
  // [R27] Edge detection
  assign fall_cs  = st_reg.prev[3] && !cs_n;
  assign rise_cs  = !st_reg.prev[3] && cs_n;
  assign rise_sck = !st_reg.prev[2] && sck;
  assign fall_sck = st_reg.prev[2] && !sck;
  assign guard_fall = st_reg.guard_prev && !guard_s2_reg;

  // [R23] Status layout
  assign status_w = {st_reg.nv[2], 3'b000, st_reg.nv[1:0],
                     st_reg.permit, st_reg.busy};

  function automatic logic cmd_is(input logic [7:0] op, input logic [7:0] c);
    cmd_is = (op & SEESF_CMD_MASK) == c;
  endfunction : cmd_is

  always_comb begin
    st_next = st_reg;
    st_next.prev = sync2_reg;
    st_next.guard_prev = guard_s2_reg;
    st_next.nv_pulse = 1'b0;
    if (st_reg.rxv && fifo_in_ready) begin
      st_next.rxv = 1'b0;
    end
    // [R6] Stored bits, zero as shipped
    if (!st_reg.nv_loaded) begin
      st_next.nv = nv_bits_in;
      st_next.nv_loaded = 1'b1;
    end
    // [R15] Write cycle runs on regardless
    if (st_reg.busy) begin
      if (st_reg.wcnt == 32'h0000_0000) begin
        st_next.busy = 1'b0;
        st_next.permit = 1'b0;
      end else begin
        st_next.wcnt = st_reg.wcnt - 32'h0000_0001;
      end
    end
    // [R16] Suspend entry and exit in clock low
    // [R18] Exit deferred to low
    if (cs_n) begin
      st_next.susp = 1'b0;
    end else if (!sck) begin
      st_next.susp = !hold_n;
    end
    // [R21] Guard falling aborts pending write
    if (guard_fall && !cs_n && st_reg.nv[2]) begin
      st_next.wr_pend = 1'b0;
    end
    if (fall_cs) begin
      // [R3] Fresh opcode after toggle
      // [R5] Select on falling edge only
      st_next.state = SEESF_OPCODE;
      st_next.bitcnt = 3'h0;
      st_next.wr_pend = 1'b0;
    end else if (rise_cs || cs_n) begin
      // [R10] Deselected output floats
      st_next.oe = 1'b0;
      st_next.state = SEESF_IDLE;
      st_next.rd_array = 1'b0;
      st_next.wr_array = 1'b0;
      st_next.sr_wr = 1'b0;
      if (rise_cs && st_reg.susp) begin
        // [R19] Abort on deselect in suspend
        st_next.permit = 1'b0;
        st_next.wr_pend = 1'b0;
      end else if (rise_cs && st_reg.wr_pend) begin
        // [R20] Guard pin inhibit
        // [R22] Pin ignored when enable clear
        if (guard_s2_reg || !st_reg.nv[2]) begin
          // [R26] Only nonvolatile bits change
          st_next.nv = st_reg.nv_pend;
          st_next.nv_pulse = 1'b1;
          st_next.busy = 1'b1;
          st_next.wcnt = WRITE_CYCLES[31:0];
        end
        st_next.wr_pend = 1'b0;
      end
    end else if (st_reg.susp) begin
      // [R17] Suspended output floats
      st_next.oe = 1'b0;
    end else begin
      if (rise_sck && st_reg.state != SEESF_REJECT
          && st_reg.state != SEESF_IDLE) begin
        // [R7] Capture on rising edge
        // [R11] MSB first shift in
        st_next.shreg = {st_reg.shreg[6:0], sdi};
        st_next.bitcnt = st_reg.bitcnt + 3'h1;
        if (st_reg.bitcnt == 3'h7) begin
          if (st_reg.state == SEESF_OPCODE) begin
            // [R13] First byte is opcode
            st_next.state = SEESF_REJECT;
            if (st_reg.busy) begin
              if (cmd_is({st_reg.shreg[6:0], sdi}, STATUS_READ_CMD)) begin
                st_next.state = SEESF_READ;
                st_next.txreg = status_w;
              end
            end else if (cmd_is({st_reg.shreg[6:0], sdi}, LATCH_SET_CMD)) begin
              st_next.permit = 1'b1;
              st_next.state = SEESF_DATA;
            end else if (cmd_is({st_reg.shreg[6:0], sdi},
                                LATCH_CLEAR_CMD)) begin
              // [R25] Clear ignores guard pin
              st_next.permit = 1'b0;
              st_next.state = SEESF_DATA;
            end else if (cmd_is({st_reg.shreg[6:0], sdi},
                                STATUS_READ_CMD)) begin
              st_next.state = SEESF_READ;
              st_next.txreg = status_w;
            end else if (cmd_is({st_reg.shreg[6:0], sdi},
                                STATUS_WRITE_CMD)) begin
              st_next.state = SEESF_DATA;
              st_next.sr_wr = 1'b1;
            end else if (cmd_is({st_reg.shreg[6:0], sdi},
                                ARRAY_READ_CMD)) begin
              st_next.state = SEESF_READ;
              st_next.rd_array = 1'b1;
              st_next.txreg = fifo_out;
            end else if (cmd_is({st_reg.shreg[6:0], sdi},
                                ARRAY_WRITE_CMD)) begin
              st_next.state = SEESF_DATA;
              st_next.wr_array = st_reg.permit;
            end
            // [R14] Unknown opcode rejected
            st_next.shreg = {st_reg.shreg[6:0], sdi};
          end else if (st_reg.state == SEESF_DATA) begin
            if (st_reg.sr_wr && st_reg.permit && !st_reg.wr_pend) begin
              st_next.nv_pend = {st_reg.shreg[6], st_reg.shreg[2:1]};
              st_next.wr_pend = 1'b1;
            end
            st_next.rxd = {st_reg.shreg[6:0], sdi};
            st_next.rxv = 1'b1;
          end
        end
      end
      if (fall_sck && st_reg.state == SEESF_READ) begin
        // [R12] MSB first output on falling edge
        st_next.out_bit = st_reg.txreg[7];
        st_next.oe = 1'b1;
        st_next.txreg = {st_reg.txreg[6:0], 1'b0};
        if (st_reg.bitcnt == 3'h0) begin
          st_next.out_bit = st_reg.rd_array ? fifo_out[7] : status_w[7];
          st_next.txreg = st_reg.rd_array ? {fifo_out[6:0], 1'b0}
                                          : {status_w[6:0], 1'b0};
        end
      end
    end
  end

  // [R1] Held in reset until released
  // [R4] Power-up defaults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.state <= SEESF_IDLE;
      st_reg.prev  <= 4'hF;
      st_reg.guard_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  seesf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (st_reg.rxd),
    .in_valid  (st_reg.rxv),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (rx_ready)
  );

  assign ser_out            = st_reg.out_bit;
  assign ser_out_oe         = st_reg.oe;
  assign nv_bits_out        = st_reg.nv;
  assign nv_write_pulse     = st_reg.nv_pulse;
  assign rx_data            = fifo_out;
  assign rx_valid           = fifo_out_valid;
  assign array_read_active  = st_reg.rd_array;
  assign array_write_active = st_reg.wr_array;
  assign status_value       = status_w;
  assign selected           = st_reg.state != SEESF_IDLE;
endmodule : seesf_frontend
`default_nettype wire

// [shared/seesf_pkg.sv]
// Constants and types for the serial EEPROM SPI front end
// What this block and its master do
// [R1] Ignore every instruction until power-on reset has released the device.
// [R2] Master waits the startup wait time after supply is stable.
// [R3] Select, deselect without clocks resets the interface for a fresh opcode.
// [R4] Power-up: standby, deselected, not suspended, latch and cycle flag zero.
// [R5] Active state entered only on a falling chip select edge.
// [R6] Shipped state: array all ones, guard enable and block guards zero.
// [R7] Capture input on rising clock, launch output on falling clock.
// [R8] Master keeps clock idle level fixed per mode around transactions.
// [R9] Master generates the clock; device is always a slave.
// [R10] Deselected: ignore serial input, output in high impedance.
// [R11] Shift in most significant bit first from first rising edge.
// [R12] Read data leaves MSB first from first falling edge after opcode.
// [R13] First byte after chip select falls is the opcode.
// [R14] Unknown opcode: accept nothing, output floats until next select.
// [R15] Suspend never pauses the internal write cycle.
// [R16] Suspend entered only while selected, aligned to clock low phase.
// [R17] Suspended: output floats, input and clock ignored, guard pin live.
// [R18] Leaving suspend happens only in a clock low phase.
// [R19] Deselect while suspended aborts operation and clears permit latch.
// [R20] Guard pin low with guard enable set inhibits status writes.
// [R21] Guard pin falling while selected aborts pending status write.
// [R22] Guard enable zero makes the guard pin ignored entirely.
// [R23] Status register: bit7 enable, bits3:2 block guards, bit1 latch, bit0.
// [R24] Master sets the permit latch before every write instruction.
// [R25] Latch-clear instruction clears the latch regardless of guard pin.
// [R26] Status write changes only guard enable and block guard bits.
// [R27] Synchronise and edge-detect all link inputs on the system clock; data in and suspend are only synchronised.
`default_nettype none
package seesf_pkg;
  localparam logic [7:0] SEESF_CMD_MASK     = 8'hF7;
  localparam logic [7:0] LATCH_SET_CMD      = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD    = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD    = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD   = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD     = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_CMD    = 8'h02;
  localparam int         GUARD_EN_POS       = 7;
  localparam int         BLOCK_HI_POS       = 3;
  localparam int         BLOCK_LO_POS       = 2;
  localparam int         PERMIT_POS         = 1;
  localparam int         CYCLE_POS          = 0;
  localparam logic [7:0] STATUS_NV_MASK     = 8'h8C;
  localparam logic [2:0] NV_SHIPPED         = 3'h0;
  localparam logic [7:0] ARRAY_SHIPPED      = 8'hFF;
  localparam int         CLK_MHZ            = 50;
  localparam int         WRITE_CYCLE_MS     = 5;
  localparam int         WRITE_CYCLE_CYC    = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int         STARTUP_WAIT_US    = 100;
  localparam int         STARTUP_WAIT_CYC   = STARTUP_WAIT_US * CLK_MHZ;
  typedef enum logic [4:0] {
    SEESF_IDLE   = 5'b00001,
    SEESF_OPCODE = 5'b00010,
    SEESF_DATA   = 5'b00100,
    SEESF_READ   = 5'b01000,
    SEESF_REJECT = 5'b10000
  } seesf_state_e;
endpackage : seesf_pkg
`default_nettype wire

// [dv/seesf_frontend_asserts.sv]
// Checker watching the SPI front end ports
`default_nettype none
module seesf_frontend_asserts #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       chip_sel_n,
  input wire logic       ser_clk,
  input wire logic       suspend_n,
  input wire logic       write_guard_n,
  input wire logic       ser_out_oe,
  input wire logic       nv_write_pulse,
  input wire logic [7:0] status_value,
  input wire logic       selected
);
  localparam int BUSY_MAX = WRITE_CYCLES + 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Deselected output floats
  property p_desel_float; chip_sel_n [*5] |-> !ser_out_oe; endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("output driven while deselected");
  property p_reset_state;
    $fell(sys_rst) |-> status_value[1:0] == 2'b00 && !ser_out_oe && !selected;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state wrong after reset");
  property p_sel_cs; $rose(selected) |-> !chip_sel_n; endproperty
  a_sel_cs: assert property (p_sel_cs)
    else $error("selected without chip select");
  property p_guard;
    nv_write_pulse |-> $past(write_guard_n, 2) || !$past(status_value[7]);
  endproperty
  a_guard: assert property (p_guard)
    else $error("status write while guarded");
  property p_permit; nv_write_pulse |-> $past(status_value[1]); endproperty
  a_permit: assert property (p_permit)
    else $error("status write without permit");
  property p_busy_min; $rose(status_value[0]) |-> status_value[0] [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("write cycle cut short");
  property p_busy_max;
    $rose(status_value[0]) |-> ##[1:BUSY_MAX] !status_value[0];
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("write cycle too long");
  property p_susp_float;
    (!suspend_n && !chip_sel_n && !ser_clk) [*6] |-> !ser_out_oe;
  endproperty
  a_susp_float: assert property (p_susp_float)
    else $error("output driven while suspended");
endmodule : seesf_frontend_asserts
`default_nettype wire

// [dv/seesf_master_model.sv]
// SPI master model driving the serial pins
`default_nettype none
module seesf_master_model (
  input  wire logic clk,
  input  wire logic ser_out,
  input  wire logic ser_out_oe,
  output var logic  chip_sel_n = 1'b1,
  output var logic  ser_clk = 1'b0,
  output var logic  ser_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle = 1'b0;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk
  task automatic frame_start();
    ser_clk <= idle;
    wait_clk(4);
    chip_sel_n <= 1'b0;
    wait_clk(8);
  endtask : frame_start
  task automatic frame_end();
    ser_clk <= idle;
    wait_clk(4);
    chip_sel_n <= 1'b1;
    ser_in <= ~ser_in;
    wait_clk(8);
  endtask : frame_end
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      ser_clk <= 1'b0;
      ser_in <= tx[i];
      wait_clk(4);
      ser_clk <= 1'b1;
      wait_clk(4);
      rx[i] = ser_out_oe ? ser_out : 1'bx;
    end
  endtask : xbyte
endmodule : seesf_master_model
`default_nettype wire

// [dv/seesf_frontend_tb.sv]
// Testbench for the SPI front end
`default_nettype none
module seesf_frontend_tb;
  import seesf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 20;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       suspend_n = 1'b1;
  logic       write_guard_n = 1'b1;
  logic       rx_ready = 1'b1;
  logic [2:0] nv_stored = NV_SHIPPED;
  logic       chip_sel_n, ser_clk, ser_in, ser_out, ser_out_oe;
  logic       nv_write_pulse, rx_valid, rd_act, wr_act, selected;
  logic [2:0] nv_bits_out;
  logic [7:0] rx_data, status_value, v, d;
  int         bad_count = 0;
  int         comparisons = 0;
  always #10 clk = ~clk;
  seesf_frontend #(.WRITE_CYCLES(WC)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .chip_sel_n(chip_sel_n), .ser_clk(ser_clk), .ser_in(ser_in),
    .suspend_n(suspend_n), .write_guard_n(write_guard_n), .ser_out(ser_out),
    .ser_out_oe(ser_out_oe), .nv_bits_in(nv_stored),
    .nv_bits_out(nv_bits_out), .nv_write_pulse(nv_write_pulse),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(8'h00), .array_read_active(rd_act),
    .array_write_active(wr_act), .status_value(status_value),
    .selected(selected));
  seesf_master_model master_u (.clk(clk), .ser_out(ser_out),
    .ser_out_oe(ser_out_oe), .chip_sel_n(chip_sel_n), .ser_clk(ser_clk),
    .ser_in(ser_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_idle();
    int i;
    for (i = 0; i < 100 && status_value[0] !== 1'b0; i++) @(posedge clk);
    if (i == 100) begin
      bad_count++;
      test_done();
    end
  endtask : wait_idle
  task automatic rd(output logic [7:0] r);
    master_u.frame_start();
    master_u.xbyte(STATUS_READ_CMD, r);
    master_u.xbyte(8'h00, r);
    master_u.frame_end();
  endtask : rd
  task automatic op1(input logic [7:0] op);
    master_u.frame_start();
    master_u.xbyte(op, d);
    master_u.frame_end();
  endtask : op1
  task automatic sr_write(input logic [7:0] s, input logic pin_drop);
    op1(LATCH_SET_CMD);
    master_u.frame_start();
    master_u.xbyte(STATUS_WRITE_CMD, d);
    master_u.xbyte(s, d);
    write_guard_n <= write_guard_n & ~pin_drop;
    master_u.frame_end();
    write_guard_n <= write_guard_n | pin_drop;
    wait_idle();
    rd(v);
  endtask : sr_write
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    chk(8'(ser_out_oe), 8'h00);
    rd(v);
    chk(v, {NV_SHIPPED[2], 3'h0, NV_SHIPPED[1:0], 2'h0});
    op1(LATCH_SET_CMD);
    rd(v);
    chk(v, 8'h02);
    write_guard_n <= 1'b0;
    op1(LATCH_CLEAR_CMD);
    write_guard_n <= 1'b1;
    rd(v);
    chk(v, 8'h00);
    master_u.frame_start();
    master_u.xbyte(8'hA5, d);
    master_u.xbyte(8'h00, d);
    chk(8'(ser_out_oe), 8'h00);
    master_u.frame_end();
  endtask : t_latch
  task automatic t_guard();
    sr_write(8'hFF, 1'b0);
    chk(v, 8'h8C);
    chk(8'(nv_bits_out), 8'h07);
    sr_write(8'h00, 1'b1);
    chk(v & STATUS_NV_MASK, 8'h8C);
    write_guard_n <= 1'b0;
    sr_write(8'h00, 1'b0);
    chk(v & STATUS_NV_MASK, 8'h8C);
    write_guard_n <= 1'b1;
    sr_write(8'h00, 1'b0);
    chk(v, 8'h00);
    write_guard_n <= 1'b0;
    sr_write(8'h0C, 1'b0);
    chk(v, 8'h0C);
    write_guard_n <= 1'b1;
  endtask : t_guard
  task automatic t_suspend();
    op1(LATCH_SET_CMD);
    master_u.frame_start();
    suspend_n <= 1'b0;
    master_u.wait_clk(12);
    chk(8'(ser_out_oe), 8'h00);
    master_u.frame_end();
    suspend_n <= 1'b1;
    rd(v);
    chk(v, 8'h0C);
    master_u.frame_start();
    suspend_n <= 1'b0;
    master_u.wait_clk(12);
    master_u.xbyte(8'hFF, d);
    suspend_n <= 1'b1;
    master_u.wait_clk(12);
    master_u.xbyte(STATUS_READ_CMD, v);
    master_u.xbyte(8'h00, v);
    master_u.frame_end();
    chk(v, 8'h0C);
  endtask : t_suspend
  task automatic t_mode3();
    master_u.idle = 1'b1;
    rd(v);
    chk(v, 8'h0C);
    master_u.frame_start();
    master_u.xbyte(8'hA5, d);
    master_u.frame_end();
    master_u.frame_start();
    master_u.frame_end();
    rd(v);
    chk(v, 8'h0C);
    master_u.idle = 1'b0;
  endtask : t_mode3
  task automatic t_fifo();
    op1(LATCH_SET_CMD);
    rx_ready <= 1'b0;
    master_u.frame_start();
    master_u.xbyte(ARRAY_WRITE_CMD, d);
    for (int i = 0; i < 17; i++) master_u.xbyte(8'(i), d);
    chk(8'(wr_act), 8'h01);
    master_u.frame_end();
    for (int i = 0; i < 16; i++) begin
      chk(8'(rx_valid), 8'h01);
      chk(rx_data, 8'(i));
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      @(posedge clk);
    end
    rx_ready <= 1'b1;
    master_u.frame_start();
    master_u.xbyte(ARRAY_READ_CMD, d);
    chk(8'(rd_act), 8'h01);
    master_u.frame_end();
    chk(8'(rd_act), 8'h00);
  endtask : t_fifo
  task automatic t_reset();
    nv_stored <= 3'h5;
    sys_rst   <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (STARTUP_WAIT_CYC) @(posedge clk);
    chk(8'(ser_out_oe), 8'h00);
    chk(8'(selected), 8'h00);
    rd(v);
    chk(v, {nv_stored[2], 3'h0, nv_stored[1:0], 2'h0});
  endtask : t_reset
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (STARTUP_WAIT_CYC) @(posedge clk);
    t_latch();
    t_guard();
    t_suspend();
    t_mode3();
    t_fifo();
    t_reset();
    test_done();
  end
endmodule : seesf_frontend_tb
bind seesf_frontend seesf_frontend_asserts #(.WRITE_CYCLES(WRITE_CYCLES))
  chk_u (.clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
  .ser_clk(ser_clk), .suspend_n(suspend_n), .write_guard_n(write_guard_n),
  .ser_out_oe(ser_out_oe), .nv_write_pulse(nv_write_pulse),
  .status_value(status_value), .selected(selected));
`default_nettype wire
